// ==== design/dbt_byte_counter.sv ====
`timescale 1ns/1ns
`default_nettype none
module dbt_byte_counter
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  // control
  input  wire logic       tick,
  input  wire logic       load,
  input  wire logic [7:0] load_value,
  input  wire logic       wr,
  input  wire logic [7:0] wr_value,
  // state
  output logic [7:0]      count_q,
  output logic            wrap
);

  logic [7:0] count_d;

  assign wrap = tick && (count_q == 8'hFF);
  assign count_d = wr ? wr_value :
                   (wrap && load) ? load_value :
                   tick ? count_q + 8'h01 : count_q;

  always_ff @(posedge clock)
  begin
    if (srst)
      count_q <= 8'h00;
    else
      count_q <= count_d;
  end

endmodule
`default_nettype wire

// ==== design/dbt_clock_select.sv ====
`timescale 1ns/1ns
`default_nettype none
module dbt_clock_select
  import dbt_pkg::*;
(
  // mode bits
  input  wire logic     fast,
  input  wire logic     ext_sel,
  // tick sources
  input  wire logic     tick_div12,
  input  wire logic     tick_ext8,
  // selected tick
  output logic          tick,
  output dbt_src_t      src
);

  assign src  = fast ? DBT_SRC_SYS : (ext_sel ? DBT_SRC_EXT8 : DBT_SRC_DIV12);
  assign tick = (src == DBT_SRC_SYS) ? 1'b1 :
                (src == DBT_SRC_EXT8) ? tick_ext8 : tick_div12;

endmodule
`default_nettype wire

// ==== design/dbt_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "dbt_defines.svh"
module dbt_timer
  import dbt_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  // external oscillator
  input  wire logic        ext_osc,
  // interrupt
  output logic             irq
);

  // ==========================================================
  // register state
  dbt_ctrl_t  ctrl_q;
  dbt_word_t  reload_q;
  logic [2:0] status_q;
  logic [2:0] enable_q;
  logic       ack_q;
  logic       wait_q;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;
  logic       irq_q;

  // ==========================================================
  // external oscillator sync and divider
  logic       ext_s1_q;
  logic       ext_s2_q;
  logic       ext_s3_q;
  logic       ext_lvl_q;
  logic [2:0] ext_div_q;
  logic       ext8_q;
  logic       ext8_prev_q;
  logic [3:0] pre12_q;

  // change counts once second and third stage agree
  wire ext_agree  = (ext_s2_q == ext_s3_q);
  wire ext_rise   = ext_agree && ext_s3_q && !ext_lvl_q;
  wire ext_div_wr = ext_rise && (ext_div_q == `DBT_EXT_DIV - 3'd1);
  wire tick_ext8  = ext_div_wr && !ext8_q;
  wire capture_ev = ext8_prev_q && !ext8_q;
  wire tick_div12 = (pre12_q == `DBT_SYS_DIV - 4'd1);
  wire [2:0] ext_div_d = ext_div_wr ? 3'd0 : ext_div_q + 3'd1;
  wire [3:0] pre12_d   = tick_div12 ? 4'd0 : pre12_q + 4'd1;

  // first stage may go metastable, so only the second stage reads it
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end
    else
    begin
      ext_s1_q <= ext_osc;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      ext_lvl_q <= 1'b0;
    else if (ext_agree)
      ext_lvl_q <= ext_s3_q;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      ext_div_q <= 3'd0;
    else if (ext_rise)
      ext_div_q <= ext_div_d;
  end

  // both reset low like the parked oscillator: no false capture
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ext8_q      <= 1'b0;
      ext8_prev_q <= 1'b0;
    end
    else
    begin
      if (ext_div_wr)
        ext8_q <= !ext8_q;
      ext8_prev_q <= ext8_q;
    end
  end

  // free running: the first tick after a start may come early
  always_ff @(posedge clock)
  begin
    if (srst)
      pre12_q <= 4'd0;
    else
      pre12_q <= pre12_d;
  end

  // ==========================================================
  // clock selection
  logic     tick_lo_src;
  logic     tick_hi_src;

  // in 16-bit mode the high byte follows the low byte's source
  wire      hi_fast = ctrl_q.split ? ctrl_q.high_fast : ctrl_q.low_fast;

  dbt_clock_select u_sel_lo
  (
    .fast       (ctrl_q.low_fast),
    .ext_sel    (ctrl_q.ext_sel),
    .tick_div12 (tick_div12),
    .tick_ext8  (tick_ext8),
    .tick       (tick_lo_src),
    .src        ()
  );

  dbt_clock_select u_sel_hi
  (
    .fast       (hi_fast),
    .ext_sel    (ctrl_q.ext_sel),
    .tick_div12 (tick_div12),
    .tick_ext8  (tick_ext8),
    .tick       (tick_hi_src),
    .src        ()
  );

  // ==========================================================
  // counters
  logic [7:0] count_lo;
  logic [7:0] count_hi;
  logic       wrap_lo;
  logic       wrap_hi;

  // taken on the first edge; writes land on the edge that shows the answer
  wire bus_take  = (avs_read || avs_write) && !ack_q;
  wire bus_rd    = avs_read && !ack_q;
  wire bus_wr    = avs_write && ack_q;
  wire sel_ctrl  = (avs_address == `DBT_ADDR_CTRL);
  wire sel_count = (avs_address == `DBT_ADDR_COUNT);
  wire sel_rel   = (avs_address == `DBT_ADDR_RELOAD);
  wire sel_stat  = (avs_address == `DBT_ADDR_STATUS);
  wire sel_clr   = (avs_address == `DBT_ADDR_CLEAR);
  wire sel_en    = (avs_address == `DBT_ADDR_ENABLE);
  wire mapped    = sel_ctrl | sel_count | sel_rel | sel_stat | sel_clr
                   | sel_en;

  wire wr_cnt_lo = bus_wr && sel_count && avs_byteenable[0];
  wire wr_cnt_hi = bus_wr && sel_count && avs_byteenable[1];
  wire wr_rel_lo = bus_wr && sel_rel && avs_byteenable[0];
  wire wr_rel_hi = bus_wr && sel_rel && avs_byteenable[1];
  wire wr_ctrl   = bus_wr && sel_ctrl && avs_byteenable[0];
  wire wr_en     = bus_wr && sel_en && avs_byteenable[0];
  wire tick_lo   = ctrl_q.run && tick_lo_src;
  wire tick_hi   = ctrl_q.run && (ctrl_q.split ? tick_hi_src : wrap_lo);

  // auto-reload: split low reloads from low byte, 16-bit reloads both
  wire reload_lo = ctrl_q.split || wrap_hi;
  wire capture   = ctrl_q.capture_en && capture_ev;

  dbt_byte_counter u_cnt_lo
  (
    .clock      (clock),
    .srst       (srst),
    .tick       (tick_lo),
    .load       (reload_lo && !capture),
    .load_value (reload_q.low),
    .wr         (wr_cnt_lo),
    .wr_value   (avs_writedata[7:0]),
    .count_q    (count_lo),
    .wrap       (wrap_lo)
  );

  dbt_byte_counter u_cnt_hi
  (
    .clock      (clock),
    .srst       (srst),
    .tick       (tick_hi),
    .load       (!capture),
    .load_value (reload_q.high),
    .wr         (wr_cnt_hi),
    .wr_value   (avs_writedata[15:8]),
    .count_q    (count_hi),
    .wrap       (wrap_hi)
  );

  // ==========================================================
  // flags: set wins over clear
  wire [2:0] ev_set;
  assign ev_set[`DBT_ST_HIGH_OVF] = wrap_hi || capture;
  assign ev_set[`DBT_ST_LOW_OVF]  = wrap_lo;
  assign ev_set[`DBT_ST_CAPTURE]  = capture;

  wire [2:0] clr_bits = (bus_wr && sel_clr && avs_byteenable[0])
                        ? avs_writedata[2:0] : 3'b000;
  wire [2:0] status_d = ev_set | (status_q & ~clr_bits);

  // timer_ie gates both overflow flags but not capture; low flag only with its own enable
  wire irq_hi = ctrl_q.timer_ie && status_q[`DBT_ST_HIGH_OVF];
  wire irq_lo = ctrl_q.timer_ie && ctrl_q.low_ie
                && status_q[`DBT_ST_LOW_OVF];
  wire irq_cp = status_q[`DBT_ST_CAPTURE];
  wire [2:0] irq_src = {irq_cp, irq_lo, irq_hi};
  wire irq_d  = |(irq_src & enable_q);

  // ==========================================================
  // bus readback and register writes
  wire [31:0] rd_mux =
      sel_ctrl  ? {24'h000000, ctrl_q} :
      sel_count ? {16'h0000, count_hi, count_lo} :
      sel_rel   ? {16'h0000, reload_q} :
      sel_stat  ? {29'h00000000, status_q} :
      sel_en    ? {29'h00000000, enable_q} : 32'h00000000;

  // capture copies the live 16-bit count before this edge's increment
  wire [7:0]  rel_lo_d = capture ? count_lo
                       : wr_rel_lo ? avs_writedata[7:0] : reload_q.low;
  wire [7:0]  rel_hi_d = capture ? count_hi
                       : wr_rel_hi ? avs_writedata[15:8] : reload_q.high;
  wire [15:0] reload_d = {rel_hi_d, rel_lo_d};

  always_ff @(posedge clock)
  begin
    if (srst)
      ctrl_q <= `DBT_CTRL_RESET;
    else if (wr_ctrl)
      ctrl_q <= avs_writedata[7:0];
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      enable_q <= 3'b000;
    else if (wr_en)
      enable_q <= avs_writedata[2:0];
  end

  // capture assumes 16-bit auto-reload on a fast timer clock
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      reload_q <= 16'h0000;
      status_q <= 3'b000;
    end
    else
    begin
      reload_q <= reload_d;
      status_q <= status_d;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      irq_q <= 1'b0;
    else
      irq_q <= irq_d;
  end

  // one wait cycle; the answer edge is also the write edge
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ack_q  <= 1'b0;
      wait_q <= 1'b1;
    end
    else
    begin
      ack_q  <= bus_take;
      wait_q <= !bus_take;
    end
  end

  // read data and response captured on the taking edge, held until next
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rdata_q <= 32'h00000000;
      resp_q  <= 2'b00;
    end
    else
    begin
      if (bus_rd)
        rdata_q <= rd_mux;
      if (bus_take)
        resp_q <= mapped ? 2'b00 : 2'b10;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;
  assign avs_response    = resp_q;
  assign irq             = irq_q;

endmodule
`default_nettype wire

// ==== shared/dbt_defines.svh ====
`ifndef DBT_DEFINES_SVH
`define DBT_DEFINES_SVH

// register byte addresses (word aligned)
`define DBT_ADDR_CTRL      6'h00
`define DBT_ADDR_COUNT     6'h04
`define DBT_ADDR_RELOAD    6'h08
`define DBT_ADDR_STATUS    6'h0C
`define DBT_ADDR_CLEAR     6'h10
`define DBT_ADDR_ENABLE    6'h14

// control register fields
`define DBT_CTRL_RUN       0
`define DBT_CTRL_SPLIT     1
`define DBT_CTRL_HIGH_FAST 2
`define DBT_CTRL_EXT_SEL   3
`define DBT_CTRL_TIMER_IE  4
`define DBT_CTRL_LOW_IE    5
`define DBT_CTRL_LOW_FAST  6
`define DBT_CTRL_CAPTURE   7
`define DBT_CTRL_RESET     8'h00

// status / clear / enable fields
`define DBT_ST_HIGH_OVF    0
`define DBT_ST_LOW_OVF     1
`define DBT_ST_CAPTURE     2

// prescaler counts
`define DBT_SYS_DIV        4'd12
`define DBT_EXT_DIV        3'd4

`endif

// ==== shared/dbt_pkg.sv ====
package dbt_pkg;

  typedef struct packed {
    logic       capture_en;
    logic       low_fast;
    logic       low_ie;
    logic       timer_ie;
    logic       ext_sel;
    logic       high_fast;
    logic       split;
    logic       run;
  } dbt_ctrl_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } dbt_word_t;

  typedef enum logic [1:0] {
    DBT_SRC_DIV12,
    DBT_SRC_EXT8,
    DBT_SRC_SYS
  } dbt_src_t;

endpackage

// ==== verification/dbt_osc_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module dbt_osc_model
#(
  parameter int HALF_NS = 200
)
(
  // control
  input  wire logic run,
  // oscillator pin
  output logic      ext_osc
);
  // edges fall between clock rises; gated off it parks low
  initial
  begin
    ext_osc = 1'b0;
    forever
    begin
      #HALF_NS;
      ext_osc = run ? !ext_osc : 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== verification/dbt_timer_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module dbt_timer_props
(
  // clock and reset
  input wire logic        clock,
  input wire logic        srst,
  // register bus
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  // oscillator and interrupt
  input wire logic        ext_osc,
  input wire logic        irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  wire req = avs_read || avs_write;
  wire bad = avs_address > 6'h14 || avs_address[1:0] != 2'h0;
  // ==========================
  // bus answer
  ack_after_one_a:
    assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  ack_one_cycle_a:
    assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held too long");
  idle_no_ack_a:
    assert property (!req |=> avs_waitrequest)
    else $error("answer without request");
  bad_addr_err_a:
    assert property (req && avs_waitrequest && bad |=> avs_response == 2'h2)
    else $error("unmapped access not flagged");
  good_addr_ok_a:
    assert property (req && avs_waitrequest && !bad |=> avs_response == 2'h0)
    else $error("mapped access flagged");
  bad_read_zero_a:
    assert property (avs_read && avs_waitrequest && bad
                     |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a:
    assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved while idle");
  // ==========================
  // interrupt
  irq_sticky_a:
    assert property ($fell(irq) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("interrupt dropped without software write");
  reset_quiet_a:
    assert property (disable iff (1'b0) srst |=> !irq && avs_waitrequest)
    else $error("outputs not quiet after reset");
  cover property ($rose(irq));
  cover property (avs_response == 2'h2);
  cover property (avs_read && !avs_waitrequest);
endmodule
`default_nettype wire

// ==== verification/dual_byte_timer_capture_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "dbt_defines.svh"
module dual_byte_timer_capture_bench;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic        ext_osc;
  logic        irq;
  logic        osc_run = 1'b0;
  logic [31:0] q;
  logic [15:0] r1;
  int          n_mismatch = 0;
  int          tests_run = 0;
  dbt_timer u_dut (.clock(clock), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .ext_osc(ext_osc), .irq(irq));
  // period 400 ns, so divided by eight it spans 80 clocks
  dbt_osc_model #(.HALF_NS(200)) u_osc (.run(osc_run), .ext_osc(ext_osc));
  initial
  begin
    forever
      #20 clock = ~clock;
  end
  // ==========================
  // bus and checks
  task automatic acc(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0)
      @(posedge clock);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic cmp32(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] reg %h exp %h got %h", avs_address, e, g);
    end
  endtask
  task automatic irq_is(input logic e);
    repeat (3) @(posedge clock);
    tests_run++;
    if (irq !== e)
    begin
      n_mismatch++;
      $display("[FAIL] irq exp %b got %b", e, irq);
    end
  endtask
  task automatic cmp_rng(input logic [7:0] lo, input logic [7:0] hi,
                         input logic [7:0] g);
    tests_run++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      n_mismatch++;
      $display("[FAIL] count range %h..%h got %h", lo, hi, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    cmp32(e, q);
  endtask
  task automatic wait_cap;
    q = 32'h0;
    while (q[2] !== 1'b1)
      acc(1'b0, `DBT_ADDR_STATUS, 32'h0);
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #400000;
    n_mismatch++;
    conclude();
  end
  // ==========================
  // tests
  initial
  begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    rd(`DBT_ADDR_CTRL, 32'h0);
    rd(`DBT_ADDR_STATUS, 32'h0);
    rd(6'h3C, 32'h0);
    // oscillator runs but capture is off
    wr(`DBT_ADDR_RELOAD, 32'h1234);
    wr(`DBT_ADDR_COUNT, 32'hFFF0);
    osc_run <= 1'b1;
    wr(`DBT_ADDR_CTRL, 32'h45);
    repeat (200) @(posedge clock);
    wr(`DBT_ADDR_CTRL, 32'h0);
    rd(`DBT_ADDR_STATUS, 32'h3);
    rd(`DBT_ADDR_RELOAD, 32'h1234);
    repeat (50) @(posedge clock);
    rd(`DBT_ADDR_STATUS, 32'h3);
    wr(`DBT_ADDR_CLEAR, 32'h3);
    rd(`DBT_ADDR_STATUS, 32'h0);
    // low half alone wraps, high half slow at one in twelve
    wr(`DBT_ADDR_ENABLE, 32'h3);
    wr(`DBT_ADDR_COUNT, 32'h00F0);
    wr(`DBT_ADDR_CTRL, 32'h53);
    repeat (40) @(posedge clock);
    wr(`DBT_ADDR_CTRL, 32'h12);
    rd(`DBT_ADDR_STATUS, 32'h2);
    // high half ran about 43 clocks at one in twelve
    acc(1'b0, `DBT_ADDR_COUNT, 32'h0);
    cmp_rng(8'h03, 8'h04, q[15:8]);
    irq_is(1'b0);
    wr(`DBT_ADDR_CTRL, 32'h32);
    irq_is(1'b1);
    wr(`DBT_ADDR_ENABLE, 32'h0);
    irq_is(1'b0);
    wr(`DBT_ADDR_ENABLE, 32'h3);
    irq_is(1'b1);
    wr(`DBT_ADDR_CLEAR, 32'h2);
    irq_is(1'b0);
    // high half alone at full rate
    wr(`DBT_ADDR_COUNT, 32'hFF00);
    wr(`DBT_ADDR_CTRL, 32'h17);
    repeat (10) @(posedge clock);
    wr(`DBT_ADDR_CTRL, 32'h10);
    rd(`DBT_ADDR_STATUS, 32'h1);
    irq_is(1'b1);
    // both halves on external clock over eight, one tick per 80 clocks
    wr(`DBT_ADDR_COUNT, 32'h0);
    wr(`DBT_ADDR_CTRL, 32'h0B);
    repeat (400) @(posedge clock);
    wr(`DBT_ADDR_CTRL, 32'h0);
    acc(1'b0, `DBT_ADDR_COUNT, 32'h0);
    cmp_rng(8'h04, 8'h06, q[7:0]);
    cmp_rng(8'h04, 8'h06, q[15:8]);
    // capture: two successive captures lie 80 clocks apart
    wr(`DBT_ADDR_CLEAR, 32'h7);
    wr(`DBT_ADDR_ENABLE, 32'h0);
    wr(`DBT_ADDR_COUNT, 32'h0);
    wr(`DBT_ADDR_CTRL, 32'hC1);
    wait_cap();
    cmp32(32'h5, q & 32'h5);
    acc(1'b0, `DBT_ADDR_RELOAD, 32'h0);
    r1 = q[15:0];
    wr(`DBT_ADDR_CLEAR, 32'h7);
    wait_cap();
    acc(1'b0, `DBT_ADDR_RELOAD, 32'h0);
    cmp32(32'h50, {16'h0, q[15:0] - r1});
    conclude();
  end
endmodule
bind dbt_timer dbt_timer_props u_props (.clock(clock), .srst(srst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .ext_osc(ext_osc), .irq(irq));
`default_nettype wire
